// [qsfrc_pkg.sv]
package qsfrc_pkg;

  localparam int WORD_W      = 128;
  localparam int FIFO_DEPTH  = 16;
  localparam int DIV_W       = 8;
  localparam int LEN_W       = 7;
  localparam int CNT_W       = 12;
  localparam int BITS_W      = 8;
  // chip select stays active two periods (four halves) after the last edge
  localparam logic [2:0] TAIL_HALVES = 3'h4;
  localparam logic [3:0] DIN_RST     = 4'h0;

  typedef enum logic [1:0] {
    LANE_1 = 2'b00,
    LANE_2 = 2'b01,
    LANE_4 = 2'b10
  } qsfrc_lanes_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL  = 2'b11
  } qsfrc_state_e;

  typedef struct packed {
    logic [DIV_W-1:0] sclk_divide_value;
    logic [1:0]       select_to_data_delay;
    logic [LEN_W-1:0] word_len_m1;
    logic [CNT_W-1:0] word_count_m1;
    qsfrc_lanes_e     lanes;
    logic             write;
    logic             word_irq_en;
    logic             frame_irq_en;
  } qsfrc_cfg_s;

endpackage

// [qsfrc_ctrl.sv]
// Behaviour
// R01 - serial clock idles low, phase zero
// R02 - sample input lanes on falling sclk edges
// R03 - duty half, or div/2 over div+1 even
// R04 - software should prefer zero or odd divide
// R05 - select leads by delay+1 periods, trails two
// R06 - drive d1 only while select active
// R07 - change outgoing d1 on falling edges
// R08 - first bit one period before first fall
// R09 - controller only, single dual quad reads
// R10 - word 1..128 bits, 1..4096 words per frame
// R11 - select to data delay 0..3 periods
// R12 - optional word or frame done interrupt
// R13 - idle select high, sclk low, one frame
`timescale 1ns/10ps
`default_nettype none

module qsfrc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output var  logic         o_in_ready,
  output var  logic         o_out_valid,
  output var  logic [W-1:0] o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_reg];

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_in_data;
    end
  end

  // flags are registered so the ready and valid outputs come from flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_reg      <= '0;
      rd_reg      <= '0;
      cnt_reg     <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= AW'(wr_reg + 1'b1);
      end
      if (pop) begin
        rd_reg <= AW'(rd_reg + 1'b1);
      end
      cnt_reg     <= cnt_next;
      o_in_ready  <= cnt_next != (AW+1)'(DEPTH);
      o_out_valid <= cnt_next != '0;
    end
  end

  a_fifo_no_over: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

module qsfrc_ctrl (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_start,
  input  wire qsfrc_pkg::qsfrc_cfg_s        i_cfg,
  input  wire logic [qsfrc_pkg::WORD_W-1:0] i_tx_word,
  input  wire logic [3:0]                   i_d_in,
  output var  logic                         o_sclk,
  output var  logic                         o_cs_b,
  output var  logic                         o_d1_out,
  output var  logic                         o_d1_oe,
  output var  logic                         o_busy,
  output var  logic                         o_word_done,
  output var  logic                         o_frame_done,
  output var  logic                         o_irq,
  output var  logic                         o_rx_valid,
  output var  logic [qsfrc_pkg::WORD_W-1:0] o_rx_data,
  input  wire logic                         i_rx_ready
);
  localparam int WW = qsfrc_pkg::WORD_W;
  localparam int BW = qsfrc_pkg::BITS_W;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  qsfrc_pkg::qsfrc_cfg_s   cfg_reg;
  qsfrc_pkg::qsfrc_state_e state_reg;
  logic [qsfrc_pkg::DIV_W-1:0] hcnt_reg;
  logic          ph_reg;
  logic [2:0]    halves_reg;
  logic [BW-1:0] bits_reg;
  logic [qsfrc_pkg::CNT_W-1:0] words_reg;
  logic [WW-1:0] acc_reg;
  logic [WW-1:0] acc_next;
  logic [WW-1:0] tx_reg;
  logic [WW-1:0] rx_word_reg;
  logic          push_reg;
  logic [3:0]    din_s1_reg;
  logic [3:0]    din_s2_reg;
  logic          fifo_ready;
  logic          tick;
  logic          falling;
  logic          word_end;
  logic          stall;
  logic [BW-1:0] lane_n;
  logic [BW-1:0] full_len;
  logic [WW-1:0] tx_load;

  // period div+1 input clocks; zero is stretched to two clocks
  function automatic logic [qsfrc_pkg::DIV_W-1:0] half_len(
    input logic [qsfrc_pkg::DIV_W-1:0] div,
    input logic                        high
  );
    logic [qsfrc_pkg::DIV_W-1:0] half;
    half = div >> 1;
    if (div == '0) begin
      half_len = 8'h01;
    end else if (div[0]) begin
      half_len = half + 1'b1;
    end else begin
      half_len = high ? half : half + 1'b1;
    end
  endfunction

  function automatic logic [WW-1:0] tx_align(
    input logic [WW-1:0]                 word,
    input logic [qsfrc_pkg::LEN_W-1:0]   len_m1
  );
    tx_align = word << (7'h7f - len_m1);
  endfunction

  assign tick     = (state_reg != qsfrc_pkg::ST_IDLE) && (hcnt_reg == 8'h01);
  assign falling  = tick && (state_reg == qsfrc_pkg::ST_SHIFT) && ph_reg;
  assign full_len = BW'(cfg_reg.word_len_m1) + 8'h01;
  assign tx_load  = tx_align(i_tx_word, cfg_reg.word_len_m1);
  assign lane_n   = (cfg_reg.lanes == qsfrc_pkg::LANE_4) ? 8'h04 :
                    (cfg_reg.lanes == qsfrc_pkg::LANE_2) ? 8'h02 : 8'h01;
  assign word_end = falling && (bits_reg <= lane_n);
  // a new word waits until the previous one has a place in the fifo
  assign stall    = tick && !ph_reg && (state_reg == qsfrc_pkg::ST_SHIFT)
                    && (bits_reg == full_len) && push_reg && !fifo_ready;

  always_comb begin
    unique case (cfg_reg.lanes)
      qsfrc_pkg::LANE_4: acc_next = {acc_reg[WW-5:0], din_s2_reg}; // see R09
      qsfrc_pkg::LANE_2: acc_next = {acc_reg[WW-3:0], din_s2_reg[1:0]};
      default:           acc_next = {acc_reg[WW-2:0], din_s2_reg[0]};
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      din_s1_reg <= qsfrc_pkg::DIN_RST;
      din_s2_reg <= qsfrc_pkg::DIN_RST;
    end else begin
      din_s1_reg <= i_d_in;
      din_s2_reg <= din_s1_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg  <= qsfrc_pkg::ST_IDLE;
      cfg_reg    <= '0;
      hcnt_reg   <= 8'h01;
      ph_reg     <= 1'b1;
      halves_reg <= '0;
      bits_reg   <= '0;
      words_reg  <= '0;
      o_cs_b     <= 1'b1;
      o_sclk     <= 1'b0;
      o_busy     <= 1'b0;
    end else begin
      unique case (state_reg)
        qsfrc_pkg::ST_IDLE: begin
          o_sclk <= 1'b0; // see R01
          o_cs_b <= 1'b1; // see R13
          if (i_start) begin
            cfg_reg    <= i_cfg;
            state_reg  <= qsfrc_pkg::ST_LEAD;
            o_cs_b     <= 1'b0;
            o_busy     <= 1'b1;
            ph_reg     <= 1'b1;
            hcnt_reg   <= half_len(i_cfg.sclk_divide_value, 1'b1);
            // lead of delay+1 whole periods, counted in halves
            // delay three wraps to zero, which counts down eight halves
            halves_reg <= {i_cfg.select_to_data_delay + 2'h1,
                           1'b0}; // see R05 R11
            bits_reg   <= BW'(i_cfg.word_len_m1) + 8'h01; // see R10
            words_reg  <= i_cfg.word_count_m1; // see R10
          end
        end
        qsfrc_pkg::ST_LEAD: begin
          if (tick) begin
            ph_reg     <= !ph_reg;
            hcnt_reg   <= half_len(cfg_reg.sclk_divide_value, !ph_reg);
            halves_reg <= halves_reg - 3'h1;
            if (halves_reg == 3'h1) begin
              state_reg <= qsfrc_pkg::ST_SHIFT;
              o_sclk    <= 1'b1; // see R01
            end
          end else begin
            hcnt_reg <= hcnt_reg - 8'h01;
          end
        end
        qsfrc_pkg::ST_SHIFT: begin
          if (stall) begin
            hcnt_reg <= hcnt_reg;
          end else if (tick) begin
            ph_reg   <= !ph_reg;
            hcnt_reg <= half_len(cfg_reg.sclk_divide_value,
                                 !ph_reg); // see R03
            o_sclk   <= !ph_reg;
            if (falling) begin
              bits_reg <= word_end ? full_len : bits_reg - lane_n;
              if (word_end) begin
                words_reg <= words_reg - 1'b1;
                if (words_reg == '0) begin
                  state_reg  <= qsfrc_pkg::ST_TAIL;
                  halves_reg <= qsfrc_pkg::TAIL_HALVES; // see R05
                  o_sclk     <= 1'b0;
                end
              end
            end
          end else begin
            hcnt_reg <= hcnt_reg - 8'h01;
          end
        end
        qsfrc_pkg::ST_TAIL: begin
          if (tick) begin
            ph_reg     <= !ph_reg;
            hcnt_reg   <= half_len(cfg_reg.sclk_divide_value, !ph_reg);
            halves_reg <= halves_reg - 3'h1;
            if (halves_reg == 3'h1) begin
              state_reg <= qsfrc_pkg::ST_IDLE;
              o_cs_b    <= 1'b1; // see R05
              o_busy    <= 1'b0; // see R13
            end
          end else begin
            hcnt_reg <= hcnt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  // outgoing line, loaded half a period ahead of the first rising edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_reg   <= '0;
      o_d1_out <= 1'b0;
      o_d1_oe  <= 1'b0;
    end else begin
      // enable rises with select, from the config taken at the start
      if (state_reg == qsfrc_pkg::ST_IDLE) begin
        o_d1_oe <= i_start && i_cfg.write; // see R06
      end else begin
        o_d1_oe <= cfg_reg.write && !(state_reg == qsfrc_pkg::ST_TAIL && tick
                                      && halves_reg == 3'h1); // see R06
      end
      if (state_reg == qsfrc_pkg::ST_LEAD && tick && halves_reg == 3'h2) begin
        tx_reg   <= tx_load; // see R08
        o_d1_out <= tx_load[WW-1];
      end else if (falling && !stall) begin
        if (word_end) begin
          tx_reg   <= tx_load;
          o_d1_out <= tx_load[WW-1];
        end else begin
          tx_reg   <= tx_reg << 1;
          o_d1_out <= tx_reg[WW-2]; // see R07
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_reg     <= '0;
      rx_word_reg <= '0;
      push_reg    <= 1'b0;
    end else begin
      if (falling) begin
        acc_reg <= word_end ? '0 : acc_next; // see R02
      end
      if (word_end && !cfg_reg.write) begin
        rx_word_reg <= acc_next;
        push_reg    <= 1'b1;
      end else if (fifo_ready) begin
        push_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_word_done  <= 1'b0;
      o_frame_done <= 1'b0;
      o_irq        <= 1'b0;
    end else begin
      o_word_done  <= word_end;
      o_frame_done <= state_reg == qsfrc_pkg::ST_TAIL && tick
                      && halves_reg == 3'h1;
      o_irq <= (word_end && cfg_reg.word_irq_en)
               || (state_reg == qsfrc_pkg::ST_TAIL && tick
                   && halves_reg == 3'h1 && cfg_reg.frame_irq_en); // see R12
    end
  end

  qsfrc_fifo #(
    .W     (WW),
    .DEPTH (qsfrc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (push_reg),
    .i_in_data   (rx_word_reg),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

  logic [qsfrc_pkg::DIV_W-1:0] high_cnt_reg;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_cnt_reg <= '0;
    end else begin
      high_cnt_reg <= o_sclk ? high_cnt_reg + 8'h01 : 8'h00;
    end
  end

  sequence s_select_lead;
    !o_sclk [*2];
  endsequence

  a_idle_pins: assert property ( // see R13
    $past(state_reg) == qsfrc_pkg::ST_IDLE && !$past(i_start)
    |-> o_cs_b && !o_sclk) else $error("idle pins not at rest");
  a_sclk_select: assert property ( // see R01
    o_sclk |-> !o_cs_b) else $error("sclk high with select inactive");
  a_select_lead: assert property ( // see R05
    $fell(o_cs_b) |-> s_select_lead) else $error("select lead too short");
  a_select_tail: assert property ( // see R05
    $rose(o_cs_b) |-> !$past(o_sclk) && !$past(o_sclk, 4))
    else $error("select released too early");
  a_sample_fall: assert property ( // see R02
    (falling && !stall) |=> $fell(o_sclk)) else $error("sample not on fall");
  a_d1_fall: assert property ( // see R07
    ($changed(o_d1_out) && !o_cs_b && $past(state_reg) == qsfrc_pkg::ST_SHIFT)
    |-> $fell(o_sclk)) else $error("d1 moved off a falling edge");
  a_d1_enable: assert property ( // see R06
    o_d1_oe |-> !o_cs_b) else $error("d1 driven with select inactive");
  a_high_even: assert property ( // see R03
    ($fell(o_sclk) && cfg_reg.sclk_divide_value != '0
     && !cfg_reg.sclk_divide_value[0])
    |-> high_cnt_reg == (cfg_reg.sclk_divide_value >> 1))
    else $error("sclk high phase wrong");
  a_word_irq: assert property ( // see R12
    (word_end && cfg_reg.word_irq_en) |=> o_irq && o_word_done)
    else $error("word interrupt missing");
endmodule

`default_nettype wire

// [qsfrc_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none

module qsfrc_flash_model #(
  parameter logic [31:0] PAT = 32'h0
) (
  input  wire logic         i_sclk,
  input  wire logic         i_cs_b,
  input  wire logic [2:0]   i_lanes,
  input  wire logic         i_d1,
  output var  logic [3:0]   o_d,
  output var  logic [127:0] o_cap
);
  int idx = 0;

  // lane group at stream position k, top lane carries the earliest bit
  function automatic logic [3:0] grp(int k);
    for (int j = 0; j < 4; j++) begin
      grp[j] = (j < i_lanes) ? PAT[31 - ((k + i_lanes - 1 - j) % 32)]
                             : PAT[j];
    end
  endfunction

  initial o_d = 4'h5;

  // first group out at select, next ones launched on falls
  always @(negedge i_cs_b) begin
    idx = 0;
    o_cap = '0;
    o_d = grp(0);
  end

  always @(negedge i_sclk) begin
    if (!i_cs_b) begin
      idx = idx + i_lanes;
      o_d = grp(idx);
    end
  end

  // released lines flip so a stale value never passes for a real one
  always @(posedge i_cs_b) o_d = ~o_d;

  // mode zero device takes write data on rising edges
  always @(posedge i_sclk) begin
    if (!i_cs_b) o_cap = {o_cap[126:0], i_d1};
  end
endmodule

`default_nettype wire

// [tb_qsfrc_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_qsfrc_ctrl;
  localparam logic [31:0] PAT = 32'h9c3a_5e71;
  logic                  i_clk      = 1'b0;
  logic                  i_rst_b    = 1'b0;
  logic                  i_start    = 1'b0;
  logic                  i_rx_ready = 1'b0;
  logic [127:0]          i_tx_word  = 128'ha5c3;
  qsfrc_pkg::qsfrc_cfg_s i_cfg      = '0;
  logic [3:0]            i_d_in;
  logic [3:0]            fl_d;
  logic [2:0]            ln;
  logic [127:0]          rx_data;
  logic [127:0]          fl_cap;
  logic sclk, cs_b, d1, d1_oe, busy, wd, fd, irq, rx_valid;
  int n_mismatch = 0;
  int total_checks = 0;
  int hi, lo, p, run, n_wd, n_irq, n_fd;
  bit tmon = 0;
  bit rose, last, lastcs = 1;
  qsfrc_pkg::qsfrc_cfg_s rows [6] = '{
    '{8'h03, 2'h0, 7'h07, 12'h001, qsfrc_pkg::LANE_1, 1'b0, 1'b1, 1'b0},
    '{8'h04, 2'h1, 7'h0f, 12'h000, qsfrc_pkg::LANE_2, 1'b0, 1'b0, 1'b1},
    '{8'h05, 2'h3, 7'h1f, 12'h002, qsfrc_pkg::LANE_4, 1'b0, 1'b1, 1'b1},
    '{8'h03, 2'h2, 7'h7f, 12'h000, qsfrc_pkg::LANE_4, 1'b0, 1'b0, 1'b0},
    '{8'h07, 2'h2, 7'h00, 12'h000, qsfrc_pkg::LANE_1, 1'b0, 1'b1, 1'b1},
    '{8'h00, 2'h1, 7'h0f, 12'h001, qsfrc_pkg::LANE_1, 1'b1, 1'b0, 1'b1}};

  assign ln = (i_cfg.lanes == qsfrc_pkg::LANE_4) ? 3'h4 :
              (i_cfg.lanes == qsfrc_pkg::LANE_2) ? 3'h2 : 3'h1;
  assign i_d_in = {fl_d[3:2], d1_oe ? d1 : fl_d[1], fl_d[0]};

  qsfrc_ctrl dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_cfg(i_cfg), .i_tx_word(i_tx_word), .i_d_in(i_d_in), .o_sclk(sclk),
    .o_cs_b(cs_b), .o_d1_out(d1), .o_d1_oe(d1_oe), .o_busy(busy),
    .o_word_done(wd), .o_frame_done(fd), .o_irq(irq),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(i_rx_ready));

  qsfrc_flash_model #(.PAT(PAT)) fl_u (.i_sclk(sclk), .i_cs_b(cs_b),
    .i_lanes(ln), .i_d1(i_d_in[1]), .o_d(fl_d), .o_cap(fl_cap));

  always #10 i_clk = ~i_clk;

  task automatic cmp(string nm, logic [127:0] exp, logic [127:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [127:0] ew(int k, int n);
    ew = '0;
    for (int b = 0; b < n; b++) ew = {ew[126:0], PAT[31 - ((k*n + b) % 32)]};
  endfunction

  // runs of sclk levels counted at the settled half of each clock
  always @(negedge i_clk) begin
    n_wd += wd;
    n_irq += irq;
    n_fd += fd;
    if (tmon) begin
      cmp("d1_oe", !cs_b && i_cfg.write, d1_oe);
      if (cs_b) cmp("idle_sclk", 0, sclk);
      if (!cs_b && sclk !== last) begin
        if (sclk) cmp("lead_low", rose ? lo :
          p * (i_cfg.select_to_data_delay + 1), run);
        else cmp("high", hi, run);
        rose |= sclk;
        run = 0;
      end
      if (cs_b && !lastcs) cmp("tail", 2 * p, run);
    end
    run = cs_b ? 0 : run + 1;
    last = sclk;
    lastcs = cs_b;
  end

  task automatic start(qsfrc_pkg::qsfrc_cfg_s c, bit mon);
    @(posedge i_clk);
    i_cfg <= c;
    i_start <= 1'b1;
    n_wd = 0;
    n_irq = 0;
    n_fd = 0;
    rose = 0;
    tmon = mon;
    p = (c.sclk_divide_value == 0) ? 2 : c.sclk_divide_value + 1;
    hi = p / 2;
    lo = p - hi;
    // held while busy so the extra starts must be ignored
    repeat (3) @(posedge i_clk);
    i_start <= 1'b0;
  endtask

  task automatic finish_frame(qsfrc_pkg::qsfrc_cfg_s c);
    int t = 0;
    int nw = c.word_count_m1 + 1;
    while (busy !== 1'b0 && t < 20000) begin
      @(negedge i_clk);
      t++;
    end
    // one more clock cycle so the pulse counters have taken the last pulses
    @(negedge i_clk);
    cmp("idle", 0, busy);
    cmp("words", nw, n_wd);
    cmp("frames", 1, n_fd);
    cmp("irq", (c.word_irq_en ? nw : 0) + c.frame_irq_en, n_irq);
  endtask

  task automatic drain(int n, int len);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (rx_valid !== 1'b1 && t < 5000) begin
        @(negedge i_clk);
        t++;
      end
      cmp("rx", ew(k, len), rx_data);
      @(posedge i_clk) i_rx_ready <= 1'b1;
      @(posedge i_clk) i_rx_ready <= 1'b0;
      @(negedge i_clk);
    end
    cmp("empty", 0, rx_valid);
  endtask

  task automatic idle_chk;
    @(negedge i_clk);
    cmp("rst", {1'b1, 1'b0, 1'b0, 1'b0}, {cs_b, sclk, busy, rx_valid});
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    tally_and_finish;
  end

  // odd or zero divides elsewhere, even one on purpose
  initial begin
    repeat (7) @(posedge i_clk);
    idle_chk;
    @(posedge i_clk) i_rst_b <= 1'b1;
    foreach (rows[i]) begin
      start(rows[i], 1'b1);
      finish_frame(rows[i]);
      drain(rows[i].write ? 0 : rows[i].word_count_m1 + 1,
            rows[i].word_len_m1 + 1);
      if (rows[i].write) cmp("wr", 32'ha5c3a5c3, fl_cap[31:0]);
    end
    // full buffer must stall the link with no data lost
    start('{8'h03, 2'h0, 7'h07, 12'h013, qsfrc_pkg::LANE_1, 1'b0, 1'b0, 1'b0},
          1'b0);
    for (int t = 0; t < 3000 && n_wd < 16; t++) @(negedge i_clk);
    repeat (100) @(negedge i_clk);
    // sixteen words fill the buffer, a seventeenth waits in the push stage
    cmp("stall", {32'd17, 1'b0, 1'b1}, {n_wd, sclk, busy});
    drain(20, 8);
    finish_frame(i_cfg);
    start(rows[2], 1'b1);
    repeat (30) @(posedge i_clk);
    tmon = 0;
    i_rst_b <= 1'b0;
    idle_chk;
    @(posedge i_clk) i_rst_b <= 1'b1;
    start(rows[0], 1'b1);
    finish_frame(rows[0]);
    drain(2, 8);
    tally_and_finish;
  end
endmodule

`default_nettype wire
